// file: knk_defines.svh
// constants of the knock processor serial configuration block
`ifndef KNK_DEFINES_SVH
`define KNK_DEFINES_SVH

// ************************************************************
// word layout and address codes
// ************************************************************
`define KNK_WORD_BITS 8
`define KNK_ADDR_FREQ 2'b00
`define KNK_ADDR_GAIN 2'b10
`define KNK_ADDR_PRESC 2'b01
`define KNK_ADDR_TC 3'b110
`define KNK_ADDR_TEST 3'b111
`define KNK_PULSES 4'h8
`define KNK_CNT_MAX 4'hf

// ************************************************************
// field positions
// ************************************************************
`define KNK_Z_BIT 0
`define KNK_CH_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define KNK_RST_FREQ 6'h00
`define KNK_RST_GAIN 6'h00
`define KNK_RST_TC 5'h00
`define KNK_RST_PRESC 6'h01
`define KNK_RST_TEST 5'h00
`define KNK_RST_MHZ 5'h04

// ************************************************************
// diagnostic source selects (test field bits 4..1)
// ************************************************************
`define KNK_DIAG_FREQ 4'h1
`define KNK_DIAG_GAIN 4'h2
`define KNK_DIAG_TC 4'h3
`define KNK_DIAG_PRESC 4'h4
`define KNK_DIAG_TEST 4'h5
`define KNK_DIAG_SI 4'h6
`define KNK_DIAG_CMP 4'h7

`endif

// file: knk_pkg.sv
// types of the knock processor serial configuration block
package knk_pkg;
   // receive state of the serial filter
   typedef enum logic [1:0] {KNK_IDLE, KNK_SHIFT, KNK_REJECT} knk_rx_state_t;
   // destination of a decoded word
   typedef enum logic [2:0] {KNK_TO_FREQ, KNK_TO_GAIN, KNK_TO_PRESC, KNK_TO_TC,
      KNK_TO_TEST} knk_dest_t;
endpackage

// file: knk_link_if.sv
// link between the serial receiver and the register bank
`timescale 1ns/10ps
`default_nettype none
interface knk_link_if;
   logic word_stb;
   logic [7:0] word;
   logic sck_fall;
   logic frame_start;
   logic si_buf;
   modport rx (output word_stb, word, sck_fall, frame_start, si_buf);
   modport bank (input word_stb, word, sck_fall, frame_start, si_buf);
endinterface
`default_nettype wire

// file: knk_spi_rx.sv
// serial receiver with the eight-pulse word filter
`timescale 1ns/10ps
`default_nettype none
`include "knk_defines.svh"
module knk_spi_rx #(
   parameter int WORD_BITS = `KNK_WORD_BITS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   knk_link_if.rx lnk
);
   initial begin
      if (WORD_BITS != 8) $error("knk_spi_rx supports only 8-bit words");
   end

   knk_pkg::knk_rx_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shreg, next_shreg;
   logic sck_d, cs_d, next_stb;
   logic sck_fall, cs_fall, cs_rise;

   // ************************************************************
   // edge detection on the pins
   // ************************************************************
   assign sck_fall = sck_d & ~sck;
   assign cs_fall = cs_d & ~cs_n;
   assign cs_rise = ~cs_d & cs_n;

   // filter: count falling edges while selected, accept only exactly eight
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shreg = shreg;
      next_stb = 1'b0;
      case (state)
         knk_pkg::KNK_IDLE: begin
            if (cs_fall) begin
               next_cnt = 4'h0;
               next_state = sck ? knk_pkg::KNK_REJECT : knk_pkg::KNK_SHIFT;
            end
         end
         knk_pkg::KNK_SHIFT: begin
            if (cs_rise) begin
               // clock high at release, or wrong pulse count, drops the word
               next_stb = ~sck && (cnt == `KNK_PULSES);
               next_state = knk_pkg::KNK_IDLE;
            end else if (sck_fall) begin
               next_shreg = {shreg[6:0], si};
               next_cnt = (cnt == `KNK_CNT_MAX) ? cnt : cnt + 4'h1; // saturate, never wraps to 8
            end
         end
         knk_pkg::KNK_REJECT: begin
            if (cs_rise) next_state = knk_pkg::KNK_IDLE;
         end
         default: next_state = knk_pkg::KNK_IDLE;
      endcase
   end

   // registers of the receiver; cs_d resets high so reset is not a select edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= knk_pkg::KNK_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
         lnk.word_stb <= 1'b0;
         lnk.word <= 8'h00;
         lnk.sck_fall <= 1'b0;
         lnk.frame_start <= 1'b0;
         lnk.si_buf <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shreg <= next_shreg;
         sck_d <= sck;
         cs_d <= cs_n;
         lnk.word_stb <= next_stb;
         lnk.word <= shreg;
         lnk.sck_fall <= sck_fall & ~cs_n;
         lnk.frame_start <= cs_fall;
         lnk.si_buf <= si;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   property p_stb_eight;
      @(posedge clk) disable iff (!rst_n)
      lnk.word_stb |-> $past(cnt) == `KNK_PULSES && $past(cs_rise);
   endproperty
   a_stb_eight: assert property (p_stb_eight) else $error("word taken without eight pulses");

   property p_high_sck_rejects;
      @(posedge clk) disable iff (!rst_n)
      (state == knk_pkg::KNK_IDLE && cs_fall && sck) |=> state == knk_pkg::KNK_REJECT ##1
         !lnk.word_stb;
   endproperty
   a_high_sck_rejects: assert property (p_high_sck_rejects) else $error("high clock at select not rejected");

   property p_shift_fall;
      @(posedge clk) disable iff (!rst_n)
      (state == knk_pkg::KNK_SHIFT && sck_fall && !cs_rise) |=> shreg[0] == $past(si);
   endproperty
   a_shift_fall: assert property (p_shift_fall) else $error("data not sampled on clock fall");

   c_good_word: cover property (@(posedge clk) disable iff (!rst_n) lnk.word_stb);
   c_rejected: cover property (@(posedge clk) disable iff (!rst_n)
      state == knk_pkg::KNK_REJECT);
endmodule
`default_nettype wire

// file: knk_spi_config.sv
// knock processor serial configuration: register bank, prescaler decode, output mux
// ************************************************************
// What this block does
// - prescaler bits 4..1 map 0000..1000 to 4..24 MHz; bit 5 ignored
// - last prescaler bit 1 floats the serial output, 0 drives it
// - programming arrives as eight-bit words, one per transaction
// - shifting happens only while chip select is low
// - address decode routes each word to exactly one of five registers
// - test/channel register picks input amplifier and test conditions
// - diagnostic mux drives serial output with register, input copy or comparator
// - valid word loads its register on the rising edge of select
// - words are accepted in integrate mode as well as hold mode
// - only exactly eight pulses per word are accepted
// - 00 frequency, 10 gain, 01 prescaler; 110 time constant, 111 test
// - words travel msb first, address leading, value trailing
// - data sampled on clock falling edges after select falls
// - test word bit 0 selects channel 0 or channel 1
// ************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "knk_defines.svh"
module knk_spi_config #(
   parameter int WORD_BITS = `KNK_WORD_BITS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic int_hold,
   input wire logic test_mode_n,
   input wire logic rect_compare,
   output logic so,
   output logic so_oe,
   output logic [5:0] band_pass_filter_code,
   output logic [5:0] gain_code,
   output logic [4:0] integ_time_code,
   output logic [5:0] clock_divider_output_control,
   output logic [4:0] test_channel_code,
   output logic input_channel_bit,
   output logic [4:0] clock_freq_mhz
);
   initial begin
      if (WORD_BITS != 8) $error("knk_spi_config supports only 8-bit words");
   end

   // ************************************************************
   // functions
   // ************************************************************
   // address decode of a received word
   function automatic knk_pkg::knk_dest_t knk_decode(input logic [7:0] w);
      if (w[7:6] == `KNK_ADDR_FREQ) knk_decode = knk_pkg::KNK_TO_FREQ;
      else if (w[7:6] == `KNK_ADDR_GAIN) knk_decode = knk_pkg::KNK_TO_GAIN;
      else if (w[7:6] == `KNK_ADDR_PRESC) knk_decode = knk_pkg::KNK_TO_PRESC;
      else if (w[7:5] == `KNK_ADDR_TC) knk_decode = knk_pkg::KNK_TO_TC;
      else knk_decode = knk_pkg::KNK_TO_TEST;
   endfunction

   // external clock rate implied by the divider code; unlisted codes read zero
   function automatic logic [4:0] knk_freq(input logic [3:0] code);
      case (code)
         4'h0: knk_freq = 5'h04;
         4'h1: knk_freq = 5'h05;
         4'h2: knk_freq = 5'h06;
         4'h3: knk_freq = 5'h08;
         4'h4: knk_freq = 5'h0a;
         4'h5: knk_freq = 5'h0c;
         4'h6: knk_freq = 5'h10;
         4'h7: knk_freq = 5'h14;
         4'h8: knk_freq = 5'h18;
         default: knk_freq = 5'h00;
      endcase
   endfunction

   // ************************************************************
   // receiver
   // ************************************************************
   knk_link_if lnk ();

   knk_spi_rx #(.WORD_BITS(WORD_BITS)) u_rx (
      .clk(clk),
      .rst_n(rst_n),
      .sck(sck),
      .cs_n(cs_n),
      .si(si),
      .lnk(lnk)
   );

   // ************************************************************
   // programmable registers
   // ************************************************************
   logic [5:0] next_freq, next_gain, next_presc;
   logic [4:0] next_tc, next_test;
   knk_pkg::knk_dest_t dest;

   assign dest = knk_decode(lnk.word);

   // integrate/hold level does not gate loading, so words land in either mode
   always_comb begin
      next_freq = band_pass_filter_code;
      next_gain = gain_code;
      next_presc = clock_divider_output_control;
      next_tc = integ_time_code;
      next_test = test_channel_code;
      if (lnk.word_stb) begin
         case (dest)
            knk_pkg::KNK_TO_FREQ: next_freq = lnk.word[5:0];
            knk_pkg::KNK_TO_GAIN: next_gain = lnk.word[5:0];
            knk_pkg::KNK_TO_PRESC: next_presc = lnk.word[5:0];
            knk_pkg::KNK_TO_TC: next_tc = lnk.word[4:0];
            knk_pkg::KNK_TO_TEST: next_test = lnk.word[4:0];
            default: next_test = test_channel_code;
         endcase
      end
   end

   // ************************************************************
   // diagnostic output mux
   // ************************************************************
   logic [3:0] diag_sel;
   logic [7:0] diag_sh, next_diag_sh;
   logic next_so, next_so_oe, diag_on;

   assign diag_sel = test_channel_code[4:1];
   assign diag_on = ~test_mode_n;

   // register source is reloaded at each select fall and shifted out msb first
   always_comb begin
      next_diag_sh = diag_sh;
      if (lnk.frame_start) begin
         case (diag_sel)
            `KNK_DIAG_FREQ: next_diag_sh = {band_pass_filter_code, 2'b00};
            `KNK_DIAG_GAIN: next_diag_sh = {gain_code, 2'b00};
            `KNK_DIAG_TC: next_diag_sh = {integ_time_code, 3'b000};
            `KNK_DIAG_PRESC: next_diag_sh = {clock_divider_output_control, 2'b00};
            `KNK_DIAG_TEST: next_diag_sh = {test_channel_code, 3'b000};
            default: next_diag_sh = 8'h00;
         endcase
      end else if (lnk.sck_fall) begin
         next_diag_sh = {diag_sh[6:0], 1'b0};
      end
   end

   // outside diagnostic mode the pin carries a steady low
   always_comb begin
      next_so = 1'b0;
      if (diag_on) begin
         case (diag_sel)
            `KNK_DIAG_SI: next_so = lnk.si_buf;
            `KNK_DIAG_CMP: next_so = rect_compare;
            default: next_so = diag_sh[7];
         endcase
      end
      next_so_oe = ~clock_divider_output_control[`KNK_Z_BIT];
   end

   // all outputs leave flops; reset parks output in high impedance
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         band_pass_filter_code <= `KNK_RST_FREQ;
         gain_code <= `KNK_RST_GAIN;
         integ_time_code <= `KNK_RST_TC;
         clock_divider_output_control <= `KNK_RST_PRESC;
         test_channel_code <= `KNK_RST_TEST;
         input_channel_bit <= 1'b0;
         clock_freq_mhz <= `KNK_RST_MHZ;
         diag_sh <= 8'h00;
         so <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         band_pass_filter_code <= next_freq;
         gain_code <= next_gain;
         integ_time_code <= next_tc;
         clock_divider_output_control <= next_presc;
         test_channel_code <= next_test;
         input_channel_bit <= next_test[`KNK_CH_BIT];
         clock_freq_mhz <= knk_freq(next_presc[4:1]);
         diag_sh <= next_diag_sh;
         so <= next_so;
         so_oe <= next_so_oe;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   property p_load_freq;
      @(posedge clk) disable iff (!rst_n)
      (lnk.word_stb && lnk.word[7:6] == `KNK_ADDR_FREQ) |=>
         band_pass_filter_code == $past(lnk.word[5:0]) && $stable(gain_code);
   endproperty
   a_load_freq: assert property (p_load_freq) else $error("frequency word misrouted");

   property p_load_tc;
      @(posedge clk) disable iff (!rst_n)
      (lnk.word_stb && lnk.word[7:5] == `KNK_ADDR_TC) |=>
         integ_time_code == $past(lnk.word[4:0]) && $stable(test_channel_code);
   endproperty
   a_load_tc: assert property (p_load_tc) else $error("time constant word misrouted");

   property p_hold_regs;
      @(posedge clk) disable iff (!rst_n)
      !lnk.word_stb |=> $stable(band_pass_filter_code) && $stable(gain_code) &&
         $stable(integ_time_code) && $stable(clock_divider_output_control) &&
         $stable(test_channel_code);
   endproperty
   a_hold_regs: assert property (p_hold_regs) else $error("register changed without word");

   property p_so_enable;
      @(posedge clk) disable iff (!rst_n)
      ##1 so_oe == !$past(clock_divider_output_control[`KNK_Z_BIT]);
   endproperty
   a_so_enable: assert property (p_so_enable) else $error("output enable disagrees with z bit");

   property p_freq_24;
      @(posedge clk) disable iff (!rst_n)
      clock_divider_output_control[4:1] == 4'h8 |-> clock_freq_mhz == 5'h18;
   endproperty
   a_freq_24: assert property (p_freq_24) else $error("divider code 1000 not 24 MHz");

   property p_diag_si;
      @(posedge clk) disable iff (!rst_n)
      (diag_on && diag_sel == `KNK_DIAG_SI) |=> so == $past(lnk.si_buf);
   endproperty
   a_diag_si: assert property (p_diag_si) else $error("serial input copy not on output");

   property p_channel;
      @(posedge clk) disable iff (!rst_n)
      input_channel_bit == test_channel_code[`KNK_CH_BIT];
   endproperty
   a_channel: assert property (p_channel) else $error("channel bit out of step");

   c_int_load: cover property (@(posedge clk) disable iff (!rst_n) int_hold && lnk.word_stb);
   c_so_driven: cover property (@(posedge clk) disable iff (!rst_n) so_oe && diag_on);
   c_cmp_out: cover property (@(posedge clk) disable iff (!rst_n)
      diag_on && diag_sel == `KNK_DIAG_CMP);
endmodule
`default_nettype wire

// file: knk_host_model.sv
// host side model: spi master that frames configuration words
`timescale 1ns/10ps
`default_nettype none
module knk_host_model (
   input wire logic clk,
   output logic sck,
   output logic cs_n,
   output logic si
);
   // idle levels: clock low, select high
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // each pin level holds 4 clk cycles, four times the one-cycle sampling minimum
   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one frame; pulse counts other than 8 and glitch bits build refused frames
   task automatic frame(input logic [7:0] w, input int pulses, input logic [1:0] glitch);
      int i;
      gap(1);
      sck = glitch[0];
      gap(4);
      cs_n = 1'b0;
      gap(4);
      sck = 1'b0;
      for (i = 0; i < pulses; i++) begin
         gap(4);
         sck = 1'b1;
         // data moves while the clock is high, so it stands steady at the sampling fall
         si = w[7 - (i % 8)];
         gap(4);
         sck = 1'b0;
      end
      gap(4);
      sck = glitch[1];
      gap(4);
      cs_n = 1'b1;
      si = ~si; // released line never shows the last bit
      gap(4);
      sck = 1'b0;
      gap(4);
   endtask
endmodule
`default_nettype wire

// file: knk_processor_spi_config_tb_top.sv
// testbench of the knock processor serial configuration block
`timescale 1ns/10ps
`default_nettype none
module knock_processor_spi_config_tb_top;
   logic clk, rst_n, int_hold, test_mode_n, rect_compare;
   logic sck, cs_n, si, so, so_oe, input_channel_bit;
   logic [5:0] band_pass_filter_code, gain_code, clock_divider_output_control;
   logic [4:0] integ_time_code, test_channel_code, clock_freq_mhz;
   logic [4:0] mhz [0:8];
   int n_fail, n_checks, cycles, k;

   // ************************************************************
   // clock, parts and timeout
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk; // stands in for an oscillator well above 4 MHz
   end
   knk_host_model host_u (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si));
   knk_spi_config dut_u (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
      .int_hold(int_hold), .test_mode_n(test_mode_n), .rect_compare(rect_compare),
      .so(so), .so_oe(so_oe), .band_pass_filter_code(band_pass_filter_code),
      .gain_code(gain_code), .integ_time_code(integ_time_code),
      .clock_divider_output_control(clock_divider_output_control),
      .test_channel_code(test_channel_code), .input_channel_bit(input_channel_bit),
      .clock_freq_mhz(clock_freq_mhz));
   // a hang costs a mismatch; tests need about 2400 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ************************************************************
   // compare and report tasks
   // ************************************************************
   task automatic cmp_code(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // a frame, then time for the load to reach the outputs
   task automatic send(input logic [7:0] w, input int pulses, input logic [1:0] glitch);
      host_u.frame(w, pulses, glitch);
      repeat (4) @(negedge clk);
   endtask
   // select a register source, then catch its top two bits while the next frame runs
   task automatic diag_read(input logic [7:0] sel, input logic [1:0] exp, input string what);
      send(sel, 8, 2'b00);
      fork
         host_u.frame(sel, 8, 2'b00);
         begin
            // select falls at the fifth edge, the first clock fall at the seventeenth
            repeat (10) @(negedge clk);
            cmp_bit(so, exp[1], what);
            repeat (12) @(negedge clk);
            cmp_bit(so, exp[0], what);
         end
      join
      repeat (4) @(negedge clk);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst_n = 1'b0;
      int_hold = 1'b0;
      test_mode_n = 1'b1;
      rect_compare = 1'b0;
      n_fail = 0;
      n_checks = 0;
      cycles = 0;
      mhz = '{5'h04, 5'h05, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h14, 5'h18};
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      // reset values: output floated, divider at 4 MHz
      cmp_code({2'h0, clock_divider_output_control}, 8'h01, "divider reset");
      cmp_code({3'h0, clock_freq_mhz}, 8'h04, "mhz reset");
      cmp_bit(so_oe, 1'b0, "so_oe reset");
      $display("test reset done");

      // one word each to frequency, gain and time constant registers; test register untouched
      send(8'h2a, 8, 2'b00);
      send(8'h94, 8, 2'b00);
      send(8'hc3, 8, 2'b00);
      cmp_code({2'h0, band_pass_filter_code}, 8'h2a, "freq");
      cmp_code({2'h0, gain_code}, 8'h14, "gain");
      cmp_code({3'h0, integ_time_code}, 8'h03, "tc");
      cmp_code({3'h0, test_channel_code}, 8'h00, "test untouched");
      $display("test decode done");

      // refused frames: short, long, clock high at either select edge
      send(8'h15, 7, 2'b00);
      send(8'h15, 9, 2'b00);
      send(8'h15, 8, 2'b01);
      send(8'h15, 8, 2'b10);
      cmp_code({2'h0, band_pass_filter_code}, 8'h2a, "freq kept");
      cmp_code({2'h0, gain_code}, 8'h14, "gain kept");
      $display("test reject done");

      // every divider code 0000..1000, spare bit toggled, floated output
      for (k = 0; k < 9; k++) begin
         send({2'b01, k[0], k[3:0], 1'b1}, 8, 2'b00);
         cmp_code({2'h0, clock_divider_output_control}, {2'h0, k[0], k[3:0], 1'b1},
            "divider");
         cmp_code({3'h0, clock_freq_mhz}, {3'h0, mhz[k]}, "mhz");
      end
      cmp_bit(so_oe, 1'b0, "so floated");
      send(8'h40, 8, 2'b00);
      cmp_bit(so_oe, 1'b1, "so driven");
      cmp_code({3'h0, clock_freq_mhz}, 8'h04, "mhz 4");
      $display("test divider done");

      // channel select while integrating
      int_hold = 1'b1;
      send(8'he1, 8, 2'b00);
      cmp_bit(input_channel_bit, 1'b1, "channel 1");
      cmp_code({3'h0, test_channel_code}, 8'h01, "test reg");
      send(8'he0, 8, 2'b00);
      cmp_bit(input_channel_bit, 1'b0, "channel 0");
      int_hold = 1'b0;
      $display("test channel done");

      // diagnostic mux: comparator source on the serial output
      send(8'hee, 8, 2'b00);
      test_mode_n = 1'b0;
      rect_compare = 1'b1;
      repeat (3) @(negedge clk);
      cmp_bit(so, 1'b1, "cmp high");
      rect_compare = 1'b0;
      repeat (3) @(negedge clk);
      cmp_bit(so, 1'b0, "cmp low");
      // register sources shift out msb first, then the buffered serial input
      diag_read(8'he2, 2'b10, "diag freq");
      diag_read(8'he4, 2'b01, "diag gain");
      send(8'hec, 8, 2'b00);
      repeat (3) @(negedge clk);
      cmp_bit(so, si, "si copy");
      test_mode_n = 1'b1;
      rect_compare = 1'b1;
      repeat (3) @(negedge clk);
      cmp_bit(so, 1'b0, "normal so");
      $display("test diagnostic done");
      print_verdict();
   end
endmodule
`default_nettype wire
